// *** src/stpc_pkg.sv ***
// constants, register map and types for the timebase pll configuration block
package stpc_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [15:0] STPC_OFS_FBR = 16'h0200;
  localparam logic [15:0] STPC_OFS_CFG = 16'h0201;
  localparam logic [15:0] STPC_OFS_FREQ0 = 16'h0202;
  localparam logic [15:0] STPC_OFS_PER0 = 16'h0207;
  localparam logic [15:0] STPC_OFS_CTRL = 16'h2000;
  localparam logic [15:0] STPC_OFS_STAT = 16'h3001;
  localparam logic [15:0] STPC_OFS_IST = 16'h3010;
  localparam logic [15:0] STPC_OFS_IMSK = 16'h3011;
  localparam int STPC_FREQ_BYTES = 5;
  localparam int STPC_PER_BYTES = 3;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int STPC_CFG_DBL = 0;
  localparam int STPC_CFG_PRE_LO = 1;
  localparam int STPC_CFG_XTAL = 3;
  localparam int STPC_CTRL_CAL = 2;
  localparam int STPC_ST_LOCK = 0;
  localparam int STPC_ST_STABLE = 1;
  localparam int STPC_ST_BUSY = 2;
  // interrupt events: lock gained, lock lost, stable gained
  localparam int STPC_EV_LOCK = 0;
  localparam int STPC_EV_UNLOCK = 1;
  localparam int STPC_EV_STABLE = 2;
  localparam int STPC_EV_N = 3;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] STPC_FBR_RST = 8'h04;
  localparam logic [3:0] STPC_CFG_RST = 4'h0;
  localparam logic [39:0] STPC_FREQ_RST = 40'h00_0000_0000;
  localparam logic [19:0] STPC_PER_RST = 20'h0000a;
  localparam logic [7:0] STPC_RD_ZERO = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int STPC_CLK_HZ = 10_000_000;
  localparam int STPC_MS_PER_S = 1000;
  localparam int STPC_MS_CYC = STPC_CLK_HZ / STPC_MS_PER_S;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic xtal_amp_en;
    logic [1:0] prescale;
    logic doubler_en;
    logic [7:0] fb_ratio;
    logic [39:0] ref_freq;
  } stpc_cfg_t;

  typedef struct packed {
    logic busy;
    logic stable;
    logic locked;
  } stpc_stat_t;

endpackage

// *** src/stpc_stab_timer.sv ***
// millisecond hold-off timer that qualifies pll lock as stable
`timescale 1ns/100ps
module stpc_stab_timer #(
  parameter int MS_CYC = stpc_pkg::STPC_MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // lock and hold-off period
  input wire logic locked,
  input wire logic [19:0] period,
  // qualified status
  output logic stable
);
  import stpc_pkg::*;

  localparam int DW = $clog2(MS_CYC + 1);

  generate
    if (MS_CYC < 1) begin : g_bad
      $error("stpc_stab_timer: MS_CYC must be at least 1");
    end
  endgenerate

  logic [DW-1:0] div_r, div_nxt;
  logic [19:0] ms_r, ms_nxt;
  logic stable_r, stable_nxt;
  logic tick;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    tick = (div_r == DW'(MS_CYC - 1));
    div_nxt = div_r;
    ms_nxt = ms_r;
    stable_nxt = 1'b0;
    if (!locked) begin
      div_nxt = '0;
      ms_nxt = '0;
    end else begin
      div_nxt = tick ? '0 : DW'(div_r + 1'b1);
      if (tick && ms_r != period) begin
        ms_nxt = ms_r + 20'h00001;
      end
    end
    stable_nxt = locked && (period != 20'h00000) && (ms_r == period);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_r <= '0;
      ms_r <= '0;
      stable_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ms_r <= ms_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign stable = stable_r;

endmodule // stpc_stab_timer

// *** src/stpc_top.sv ***
// register file, lock capture and frequency model of the timebase pll
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module stpc_top #(
  parameter int MS_CYC = stpc_pkg::STPC_MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // analog pll side
  input wire logic pll_lock_in,
  input wire logic cal_busy_in,
  output stpc_pkg::stpc_cfg_t pll_cfg,
  output logic vco_cal_req,
  output logic [48:0] core_timebase_hz,
  // status and interrupt
  output stpc_pkg::stpc_stat_t stat,
  output logic irq
);
  import stpc_pkg::*;

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [7:0] fbr_r, fbr_nxt;
  logic [3:0] cfg_r, cfg_nxt;
  logic [39:0] freq_r, freq_nxt;
  logic [19:0] per_r, per_nxt;
  logic cal_r, cal_nxt;
  logic [STPC_EV_N-1:0] ist_r, ist_nxt;
  logic [STPC_EV_N-1:0] imsk_r, imsk_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic [STPC_EV_N-1:0] ev;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // lock and busy come from the analog macro, so three flops each
  logic [2:0] lk_s_r, bz_s_r;
  logic lock_q_r, lock_q_nxt;
  logic busy_q_r, busy_q_nxt;
  logic stable_w;
  logic stable_d_r;
  logic lock_d_r;
  logic [48:0] est_r, est_nxt;
  stpc_cfg_t cfg_out_r;

  always_comb begin
    lock_q_nxt = lock_q_r;
    busy_q_nxt = busy_q_r;
    if (lk_s_r[1] == lk_s_r[2]) begin
      lock_q_nxt = lk_s_r[2];
    end
    if (bz_s_r[1] == bz_s_r[2]) begin
      busy_q_nxt = bz_s_r[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lk_s_r <= 3'h0;
      bz_s_r <= 3'h0;
      lock_q_r <= 1'b0;
      busy_q_r <= 1'b0;
      lock_d_r <= 1'b0;
      stable_d_r <= 1'b0;
    end else begin
      lk_s_r <= {lk_s_r[1:0], pll_lock_in};
      bz_s_r <= {bz_s_r[1:0], cal_busy_in};
      lock_q_r <= lock_q_nxt;
      busy_q_r <= busy_q_nxt;
      lock_d_r <= lock_q_r;
      stable_d_r <= stable_w;
    end
  end

  stpc_stab_timer #(
    .MS_CYC(MS_CYC)
  ) u_stab (
    .clk(clk),
    .rst_b(rst_b),
    // stable drops with lock
    // fed the next lock level so stable never outlives locked by a cycle
    .locked(lock_q_nxt),
    .period(per_r),
    .stable(stable_w)
  );

  // ************************************************************
  // events
  // ************************************************************
  always_comb begin
    ev = '0;
    ev[STPC_EV_LOCK] = lock_q_r && !lock_d_r;
    ev[STPC_EV_UNLOCK] = !lock_q_r && lock_d_r;
    ev[STPC_EV_STABLE] = stable_w && !stable_d_r;
  end

  // ************************************************************
  // register writes and reads
  // ************************************************************
  always_comb begin
    fbr_nxt = fbr_r;
    cfg_nxt = cfg_r;
    freq_nxt = freq_r;
    per_nxt = per_r;
    cal_nxt = cal_r;
    imsk_nxt = imsk_r;
    ist_nxt = ist_r;
    rdata_nxt = STPC_RD_ZERO;
    if (wr) begin
      unique case (addr)
        STPC_OFS_FBR: fbr_nxt = wdata;
        STPC_OFS_CFG: cfg_nxt = wdata[3:0];
        STPC_OFS_CTRL: cal_nxt = wdata[STPC_CTRL_CAL];
        STPC_OFS_IMSK: imsk_nxt = wdata[STPC_EV_N-1:0];
        STPC_OFS_IST: ist_nxt = ist_r & ~wdata[STPC_EV_N-1:0];
        default: ;
      endcase
      for (int i = 0; i < STPC_FREQ_BYTES; i++) begin
        if (addr == STPC_OFS_FREQ0 + 16'(i)) begin
          freq_nxt[8*i +: 8] = wdata;
        end
      end
      for (int i = 0; i < STPC_PER_BYTES; i++) begin
        if (addr == STPC_OFS_PER0 + 16'(i)) begin
          if (i == STPC_PER_BYTES - 1) begin
            per_nxt[19:16] = wdata[3:0];
          end else begin
            per_nxt[8*i +: 8] = wdata;
          end
        end
      end
    end
    // set wins over a same-cycle clear
    ist_nxt = ist_nxt | ev;
    if (rd) begin
      unique case (addr)
        STPC_OFS_FBR: rdata_nxt = fbr_r;
        STPC_OFS_CFG: rdata_nxt = {4'h0, cfg_r};
        STPC_OFS_CTRL: rdata_nxt = {5'h00, cal_r, 2'h0};
        STPC_OFS_STAT: rdata_nxt = {5'h00, busy_q_r, stable_w, lock_q_r};
        STPC_OFS_IST: rdata_nxt = {5'h00, ist_r};
        STPC_OFS_IMSK: rdata_nxt = {5'h00, imsk_r};
        default: ;
      endcase
      for (int i = 0; i < STPC_FREQ_BYTES; i++) begin
        if (addr == STPC_OFS_FREQ0 + 16'(i)) begin
          rdata_nxt = freq_r[8*i +: 8];
        end
      end
      for (int i = 0; i < STPC_PER_BYTES; i++) begin
        if (addr == STPC_OFS_PER0 + 16'(i)) begin
          if (i == STPC_PER_BYTES - 1) begin
            rdata_nxt = {4'h0, per_r[19:16]};
          end else begin
            rdata_nxt = per_r[8*i +: 8];
          end
        end
      end
    end
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fbr_r <= STPC_FBR_RST;
      cfg_r <= STPC_CFG_RST;
      freq_r <= STPC_FREQ_RST;
      per_r <= STPC_PER_RST;
      cal_r <= 1'b0;
      ist_r <= '0;
      imsk_r <= '0;
      rdata_r <= STPC_RD_ZERO;
      irq_r <= 1'b0;
    end else begin
      fbr_r <= fbr_nxt;
      cfg_r <= cfg_nxt;
      freq_r <= freq_nxt;
      per_r <= per_nxt;
      cal_r <= cal_nxt;
      ist_r <= ist_nxt;
      imsk_r <= imsk_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ************************************************************
  // frequency model and outputs
  // ************************************************************
  // one pipeline stage; the model lags the registers by a cycle
  always_comb begin
    logic [48:0] prod;
    prod = 49'(freq_r) * 49'(fbr_r);
    if (cfg_r[STPC_CFG_DBL]) begin
      est_nxt = 49'(prod << 1);
    end else begin
      est_nxt = prod >> cfg_r[STPC_CFG_PRE_LO +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      est_r <= '0;
      cfg_out_r <= '0;
    end else begin
      est_r <= est_nxt;
      cfg_out_r <= '{xtal_amp_en: cfg_r[STPC_CFG_XTAL],
                     prescale: cfg_r[STPC_CFG_PRE_LO +: 2],
                     doubler_en: cfg_r[STPC_CFG_DBL],
                     fb_ratio: fbr_r,
                     ref_freq: freq_r};
    end
  end

  assign pll_cfg = cfg_out_r;
  assign vco_cal_req = cal_r;
  assign core_timebase_hz = est_r;
  assign stat = '{busy: busy_q_r, stable: stable_w, locked: lock_q_r};
  assign rdata = rdata_r;
  assign irq = irq_r;

endmodule // stpc_top

// *** test/stpc_chk.sv ***
// assertion checker for the timebase pll configuration block
`timescale 1ns/100ps
module stpc_chk #(
  parameter int MS_CYC = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // pll side
  input wire logic pll_lock_in,
  input wire logic cal_busy_in,
  input wire stpc_pkg::stpc_cfg_t pll_cfg,
  input wire logic vco_cal_req,
  input wire logic [48:0] core_timebase_hz,
  // status
  input wire stpc_pkg::stpc_stat_t stat,
  input wire logic irq
);
  import stpc_pkg::*;
  logic [48:0] prod;
  logic [48:0] f_exp;
  always_comb begin
    prod = 49'(pll_cfg.ref_freq) * 49'(pll_cfg.fb_ratio);
    f_exp = pll_cfg.doubler_en ? prod << 1 : prod >> pll_cfg.prescale;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ************************************************************
  // properties
  // ************************************************************
  sequence s_lock_run;
    pll_lock_in [*5];
  endsequence
  sequence s_unlock_run;
    !pll_lock_in [*5];
  endsequence
  property p_fb;
    wr && addr == STPC_OFS_FBR |-> ##2 pll_cfg.fb_ratio == $past(wdata, 2);
  endproperty
  property p_cfg;
    wr && addr == STPC_OFS_CFG |-> ##2 {pll_cfg.xtal_amp_en,
      pll_cfg.prescale, pll_cfg.doubler_en} == $past(wdata[3:0], 2);
  endproperty
  property p_freq;
    core_timebase_hz == f_exp;
  endproperty
  property p_stat;
    rd && addr == STPC_OFS_STAT |=> rdata == {5'h00, $past(stat)};
  endproperty
  property p_idle;
    !$past(rd) |-> rdata == 8'h00;
  endproperty
  property p_lock;
    s_lock_run |-> stat.locked;
  endproperty
  property p_unlock;
    s_unlock_run |-> !stat.locked && !stat.stable;
  endproperty
  property p_stab;
    $rose(stat.stable) |-> stat.locked && $past(stat.locked, 4);
  endproperty
  property p_cal;
    wr && addr == STPC_OFS_CTRL |=> vco_cal_req == $past(wdata[2]);
  endproperty
  a_fb: assert property (p_fb)
    else $error("feedback ratio not passed on");
  a_cfg: assert property (p_cfg)
    else $error("input config not passed on");
  a_freq: assert property (p_freq)
    else $error("core frequency mismatch");
  a_stat: assert property (p_stat)
    else $error("status read mismatch");
  a_idle: assert property (p_idle)
    else $error("read data not zero when idle");
  a_lock: assert property (p_lock)
    else $error("lock not reported");
  a_unlock: assert property (p_unlock)
    else $error("unlock not reported");
  a_stab: assert property (p_stab)
    else $error("stable without hold-off");
  a_cal: assert property (p_cal)
    else $error("calibrate level wrong");
endmodule // stpc_chk
bind stpc_top stpc_chk #(.MS_CYC(MS_CYC)) u_chk (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .pll_lock_in(pll_lock_in), .cal_busy_in(cal_busy_in), .pll_cfg(pll_cfg),
  .vco_cal_req(vco_cal_req), .core_timebase_hz(core_timebase_hz),
  .stat(stat), .irq(irq));

// *** test/stpc_pll_model.sv ***
// behavioural model of the analog pll and its reference source
`timescale 1ns/100ps
module stpc_pll_model #(
  parameter int LOCK_DLY = 8
) (
  // clock
  input wire logic clk,
  // control
  input wire logic cal_req,
  input wire logic ref_ok,
  // to the block
  output logic lock,
  output logic busy
);
  int cnt = 0;
  initial begin
    lock = 1'b0;
    busy = 1'b0;
  end
  // no lock while calibrating or without reference; settles after delay
  always @(posedge clk) begin
    busy <= cal_req;
    if (cal_req || !ref_ok) begin
      cnt <= 0;
      lock <= 1'b0;
    end else if (cnt < LOCK_DLY) begin
      cnt <= cnt + 1;
    end else begin
      lock <= 1'b1;
    end
  end
endmodule // stpc_pll_model

// *** test/testbench.sv ***
// self-checking bench for the timebase pll configuration block
`timescale 1ns/100ps
module testbench;
  import stpc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ref_ok = 1'b0;
  logic lock;
  logic busy;
  logic vco_cal_req;
  logic irq;
  logic [7:0] rdata;
  logic [48:0] core_timebase_hz;
  stpc_cfg_t pll_cfg;
  stpc_stat_t stat;
  int n_errors = 0;
  int compares = 0;
  always #50 clk = ~clk;
  stpc_top #(.MS_CYC(5)) uut (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pll_lock_in(lock),
    .cal_busy_in(busy), .pll_cfg(pll_cfg), .vco_cal_req(vco_cal_req),
    .core_timebase_hz(core_timebase_hz), .stat(stat), .irq(irq));
  stpc_pll_model u_pll (.clk(clk), .cal_req(vco_cal_req), .ref_ok(ref_ok),
    .lock(lock), .busy(busy));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(64'(rdata), 64'(e));
  endtask
  task automatic wait_bit(input int b, input logic v);
    int i;
    #1;
    for (i = 0; i < 400 && stat[b] !== v; i++) begin
      @(posedge clk);
      #1;
    end
    check(64'(stat[b]), 64'(v));
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    int i;
    rd_chk(STPC_OFS_FBR, 8'h04);
    rd_chk(STPC_OFS_CFG, 8'h00);
    for (i = 0; i < STPC_FREQ_BYTES; i++)
      rd_chk(STPC_OFS_FREQ0 + 16'(i), 8'h00);
    rd_chk(STPC_OFS_PER0, 8'h0a);
    rd_chk(STPC_OFS_STAT, 8'h00);
    rd_chk(16'h0210, 8'h00);
  endtask
  task automatic t_ratio;
    logic [48:0] e;
    logic [7:0] k;
    int c;
    // 73.728 MHz reference; ratio per setting keeps core in band
    wr_reg(STPC_OFS_FREQ0 + 16'h2, 8'h65);
    wr_reg(STPC_OFS_FREQ0 + 16'h3, 8'h04);
    for (c = 0; c < 16; c++) begin
      k = c[0] ? 8'h10 : 8'(8'h1f << c[2:1]);
      wr_reg(STPC_OFS_FBR, k);
      wr_reg(STPC_OFS_CFG, 8'(c) | 8'hf0);
      ticks(1);
      e = 49'(40'd73728000) * 49'(k);
      e = c[0] ? e << 1 : e >> c[2:1];
      check(64'(core_timebase_hz), 64'(e));
      check(64'(pll_cfg.xtal_amp_en), 64'(c[3]));
      check(64'(pll_cfg.fb_ratio), 64'(k));
      rd_chk(STPC_OFS_CFG, 8'(c));
    end
    wr_reg(STPC_OFS_CFG, 8'h06);
    wr_reg(STPC_OFS_FBR, 8'hff);
    ticks(1);
    check(64'(pll_cfg.fb_ratio), 64'hff);
    check(64'(core_timebase_hz), 64'(49'd73728000 * 49'd255 >> 3));
    rd_chk(STPC_OFS_FBR, 8'hff);
    wr_reg(STPC_OFS_FBR, 8'h1f);
    wr_reg(16'h0210, 8'h5a);
    rd_chk(16'h0210, 8'h00);
    wr_reg(STPC_OFS_CFG, 8'h00);
  endtask
  task automatic t_lock;
    wr_reg(STPC_OFS_PER0, 8'h01);
    wr_reg(STPC_OFS_IMSK, 8'h07);
    ref_ok <= 1'b1;
    // calibration holds lock off while busy
    wr_reg(STPC_OFS_CTRL, 8'h04);
    #1 check(64'(vco_cal_req), 64'h1);
    ticks(6);
    rd_chk(STPC_OFS_STAT, 8'h04);
    wr_reg(STPC_OFS_CTRL, 8'h00);
    wait_bit(STPC_ST_LOCK, 1'b1);
    wait_bit(STPC_ST_STABLE, 1'b1);
    rd_chk(STPC_OFS_STAT, 8'h03);
    rd_chk(STPC_OFS_IST, 8'h05);
    check(64'(irq), 64'h1);
    wr_reg(STPC_OFS_IMSK, 8'h02);
    ticks(1);
    check(64'(irq), 64'h0);
    wr_reg(STPC_OFS_IST, 8'h05);
    rd_chk(STPC_OFS_IST, 8'h00);
    ref_ok <= 1'b0;
    wait_bit(STPC_ST_LOCK, 1'b0);
    check(64'(stat.stable), 64'h0);
    ticks(2);
    check(64'(irq), 64'h1);
    rd_chk(STPC_OFS_IST, 8'h02);
    wr_reg(STPC_OFS_IST, 8'h02);
    ticks(2);
    check(64'(irq), 64'h0);
  endtask
  task automatic t_period0;
    wr_reg(STPC_OFS_PER0, 8'h00);
    ref_ok <= 1'b1;
    wait_bit(STPC_ST_LOCK, 1'b1);
    ticks(80);
    rd_chk(STPC_OFS_STAT, 8'h01);
  endtask
  task automatic test_done;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog at 20000 cycles, far beyond the expected few hundred cycles
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_ratio();
    t_lock();
    t_period0();
    test_done();
  end
endmodule // testbench
